//--- design/mtf_pkg.sv
/*
  Shared constants and types of the multimode twin flicker timer.
  Assumes a single 100 MHz clock and synchronous inputs.
*/
package mtf_pkg;

  localparam int CLK_HZ     = 100_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;

  // Timebase: the finest time resolution is one hundredth of a second.
  localparam int BASE_TICK_MS     = 10;
  localparam int BASE_TICK_CYCLES = BASE_TICK_MS * CLK_PER_MS;

  // Input filter widths.
  localparam int FILTER_LONG_MS      = 20;
  localparam int FILTER_SHORT_MS     = 1;
  localparam int FILTER_LONG_CYCLES  = FILTER_LONG_MS * CLK_PER_MS;
  localparam int FILTER_SHORT_CYCLES = FILTER_SHORT_MS * CLK_PER_MS;

  localparam int PV_W   = 14;
  localparam int DUTY_W = 7;
  localparam int DIV_W  = 7;

  // Base ticks per counting unit of each range.
  localparam logic [DIV_W-1:0] DIV_HUNDREDTHS = 7'h01;
  localparam logic [DIV_W-1:0] DIV_TENTHS     = 7'h0A;
  localparam logic [DIV_W-1:0] DIV_SECONDS    = 7'h64;

  localparam logic [PV_W-1:0]   SEC_PER_MIN  = 14'h003C;
  localparam logic [PV_W-1:0]   MINSEC_SCALE = 14'h0064;
  localparam logic [PV_W+DUTY_W-1:0] PCT_FULL = 21'h000064;
  localparam logic [PV_W+DUTY_W-1:0] PCT_HALF = 21'h000032;

  typedef enum logic [1:0] {
    MTF_RANGE_HUNDREDTHS,
    MTF_RANGE_TENTHS,
    MTF_RANGE_SECONDS,
    MTF_RANGE_MIN_SEC
  } mtf_range_type;

  typedef enum logic [1:0] {
    MTF_MODE_START_RESET,
    MTF_MODE_CUMULATIVE,
    MTF_MODE_DUTY_FLICKER,
    MTF_MODE_TWIN_FLICKER
  } mtf_mode_type;

  typedef enum logic [1:0] {
    MTF_COLOUR_RED,
    MTF_COLOUR_GREEN,
    MTF_COLOUR_ORANGE
  } mtf_colour_type;

  // Colour selections: three fixed, then pairs of inactive/active.
  localparam logic [3:0] SEL_RED          = 4'h0;
  localparam logic [3:0] SEL_GREEN        = 4'h1;
  localparam logic [3:0] SEL_ORANGE       = 4'h2;
  localparam logic [3:0] SEL_RED_GREEN    = 4'h3;
  localparam logic [3:0] SEL_GREEN_RED    = 4'h4;
  localparam logic [3:0] SEL_RED_ORANGE   = 4'h5;
  localparam logic [3:0] SEL_ORANGE_RED   = 4'h6;
  localparam logic [3:0] SEL_GREEN_ORANGE = 4'h7;
  localparam logic [3:0] SEL_ORANGE_GREEN = 4'h8;

  // Configuration as shipped: every switch off.
  localparam logic [1:0] CFG_RANGE_DEFAULT  = 2'h0;
  localparam logic       CFG_BIT_DEFAULT    = 1'h0;
  localparam logic [3:0] CFG_COLOUR_DEFAULT = 4'h0;

endpackage

//--- design/mtf_input_filter.sv
/*
  Chatter filter for one field input: a new level is accepted only after
  it has stood for the selected width. Assumes a synchronous input.
*/
`timescale 1ns/1ps
module mtf_input_filter #(
  parameter int LONG_CYCLES  = mtf_pkg::FILTER_LONG_CYCLES,
  parameter int SHORT_CYCLES = mtf_pkg::FILTER_SHORT_CYCLES
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic raw_in,
  input  wire logic short_sel,
  output logic      level_out
);

  localparam int CW = $clog2(LONG_CYCLES + 1);

  typedef struct packed {
    logic          level;
    logic [CW-1:0] cnt;
  } mtf_filter_state_type;

  mtf_filter_state_type s_reg;
  mtf_filter_state_type s_next;

  always_comb begin
    logic [CW-1:0] width;
    width  = short_sel ? CW'(SHORT_CYCLES) : CW'(LONG_CYCLES);
    s_next = s_reg;
    if (raw_in == s_reg.level) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt >= width - CW'(1)) begin
      // Shorter pulses never reach here, so chatter is rejected.
      s_next.level = raw_in;
      s_next.cnt   = '0;
    end else begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level_out = s_reg.level;

endmodule // mtf_input_filter

//--- design/mtf_timer_core.sv
/*
  Timing core of a panel timer: single-timer modes, duty flicker, twin
  flicker, power-up configuration capture and display selection.
  Assumes sys_rst models power-up and inputs are synchronous to clk.
*/
// Functional notes
// - Start-reset mode: start begins, expiry resets timer.
// - Start-reset mode: zero set keeps output off.
// - Cumulative: count only while start on.
// - Cumulative: zero set asserts output at once.
// - Duty flicker: output on first, toggles each expiry.
// - Flicker modes ignore start while running.
// - Held start at power-up or reset release starts.
// - Range switches select ON and OFF interval ranges.
// - Switches sampled only at power-up.
// - Shipped switches all off give defaults.
// - Count direction: up elapsed, down remaining.
// - Output mode picks first twin phase.
// - Filter width 20 ms or 1 ms.
// - Low-first twin: start off, invert each expiry.
// - Retentive variants keep value over power loss.
// - Instantaneous variants start twin flicker automatically.
// - Sub-display shows set time of running phase.
// - Colour fixed or follows output state.
// - Duty ON time is cycle times percent, rounded.
`timescale 1ns/1ps
module mtf_timer_core #(
  parameter int BASE_TICK_CYCLES    = mtf_pkg::BASE_TICK_CYCLES,
  parameter int FILTER_LONG_CYCLES  = mtf_pkg::FILTER_LONG_CYCLES,
  parameter int FILTER_SHORT_CYCLES = mtf_pkg::FILTER_SHORT_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          start_in,
  input  wire logic                          reset_in,
  input  wire logic                          gate_in,
  input  wire logic                          cfg_enable,
  input  wire logic [1:0]                    off_interval_range,
  input  wire logic [1:0]                    on_interval_range,
  input  wire logic                          cfg_count_down,
  input  wire logic                          cfg_on_start,
  input  wire logic                          input_filter_width,
  input  wire logic [3:0]                    display_colour_select,
  input  wire mtf_pkg::mtf_mode_type         timer_mode,
  input  wire logic                          retentive,
  input  wire logic                          instant_start,
  input  wire logic [mtf_pkg::PV_W-1:0]      set_value,
  input  wire logic [mtf_pkg::PV_W-1:0]      on_set,
  input  wire logic [mtf_pkg::PV_W-1:0]      off_set,
  input  wire logic [mtf_pkg::DUTY_W-1:0]    duty_pct,
  input  wire logic [mtf_pkg::PV_W-1:0]      retained_pv,
  output logic                               control_out,
  output logic                               running,
  output logic [mtf_pkg::PV_W-1:0]           pv_display,
  output logic [mtf_pkg::PV_W-1:0]           sub_display,
  output logic [mtf_pkg::PV_W-1:0]           pv_store,
  output mtf_pkg::mtf_colour_type            colour
);

  localparam int BW = $clog2(BASE_TICK_CYCLES);
  localparam int PW = mtf_pkg::PV_W;
  localparam int MW = mtf_pkg::PV_W + mtf_pkg::DUTY_W;

  typedef struct packed {
    logic                    cfg_done;
    mtf_pkg::mtf_range_type  on_rng;
    mtf_pkg::mtf_range_type  off_rng;
    logic                    down;
    logic                    on_first;
    logic                    short_filt;
    logic [3:0]              colour_sel;
    logic                    rel;
    logic                    resume;
    logic                    start_prev;
    logic                    running;
    logic                    phase_on;
    logic                    out;
    logic [PW-1:0]           pv;
    logic [mtf_pkg::DIV_W-1:0] presc;
    logic [BW-1:0]           base_cnt;
    logic [PW-1:0]           pv_disp;
    logic [PW-1:0]           sub_disp;
    mtf_pkg::mtf_colour_type colour;
  } mtf_core_state_type;

  mtf_core_state_type s_reg;
  mtf_core_state_type s_next;

  logic [2:0] raw_bus;
  logic [2:0] filt_bus;
  logic       start_f;
  logic       reset_f;
  logic       gate_f;

  assign raw_bus = {gate_in, reset_in, start_in};
  assign start_f = filt_bus[0];
  assign reset_f = filt_bus[1];
  assign gate_f  = filt_bus[2];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filter
      mtf_input_filter #(
        .LONG_CYCLES  (FILTER_LONG_CYCLES),
        .SHORT_CYCLES (FILTER_SHORT_CYCLES)
      ) u_filter (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .raw_in    (raw_bus[gi]),
        .short_sel (s_reg.short_filt),
        .level_out (filt_bus[gi])
      );
    end
  endgenerate

  function automatic logic [mtf_pkg::DIV_W-1:0] div_of(
    input mtf_pkg::mtf_range_type r);
    unique case (r)
      mtf_pkg::MTF_RANGE_HUNDREDTHS: div_of = mtf_pkg::DIV_HUNDREDTHS;
      mtf_pkg::MTF_RANGE_TENTHS:     div_of = mtf_pkg::DIV_TENTHS;
      mtf_pkg::MTF_RANGE_SECONDS:    div_of = mtf_pkg::DIV_SECONDS;
      mtf_pkg::MTF_RANGE_MIN_SEC:    div_of = mtf_pkg::DIV_SECONDS;
    endcase
  endfunction

  // Minutes and seconds are entered as mmss; counting runs in seconds.
  function automatic logic [PW-1:0] to_units(
    input mtf_pkg::mtf_range_type r, input logic [PW-1:0] v);
    if (r == mtf_pkg::MTF_RANGE_MIN_SEC) begin
      to_units = PW'((v / mtf_pkg::MINSEC_SCALE) * mtf_pkg::SEC_PER_MIN
                     + v % mtf_pkg::MINSEC_SCALE);
    end else begin
      to_units = v;
    end
  endfunction

  function automatic logic [PW-1:0] to_disp(
    input mtf_pkg::mtf_range_type r, input logic [PW-1:0] v);
    if (r == mtf_pkg::MTF_RANGE_MIN_SEC) begin
      to_disp = PW'((v / mtf_pkg::SEC_PER_MIN) * mtf_pkg::MINSEC_SCALE
                    + v % mtf_pkg::SEC_PER_MIN);
    end else begin
      to_disp = v;
    end
  endfunction

  function automatic mtf_pkg::mtf_colour_type colour_of(
    input logic [3:0] sel, input logic on);
    case (sel)
      mtf_pkg::SEL_GREEN:  colour_of = mtf_pkg::MTF_COLOUR_GREEN;
      mtf_pkg::SEL_ORANGE: colour_of = mtf_pkg::MTF_COLOUR_ORANGE;
      mtf_pkg::SEL_RED_GREEN:
        colour_of = on ? mtf_pkg::MTF_COLOUR_GREEN : mtf_pkg::MTF_COLOUR_RED;
      mtf_pkg::SEL_GREEN_RED:
        colour_of = on ? mtf_pkg::MTF_COLOUR_RED : mtf_pkg::MTF_COLOUR_GREEN;
      mtf_pkg::SEL_RED_ORANGE:
        colour_of = on ? mtf_pkg::MTF_COLOUR_ORANGE : mtf_pkg::MTF_COLOUR_RED;
      mtf_pkg::SEL_ORANGE_RED:
        colour_of = on ? mtf_pkg::MTF_COLOUR_RED : mtf_pkg::MTF_COLOUR_ORANGE;
      mtf_pkg::SEL_GREEN_ORANGE:
        colour_of = on ? mtf_pkg::MTF_COLOUR_ORANGE
                       : mtf_pkg::MTF_COLOUR_GREEN;
      mtf_pkg::SEL_ORANGE_GREEN:
        colour_of = on ? mtf_pkg::MTF_COLOUR_GREEN
                       : mtf_pkg::MTF_COLOUR_ORANGE;
      default: colour_of = mtf_pkg::MTF_COLOUR_RED;
    endcase
  endfunction

  logic                   twin;
  logic                   flicker;
  mtf_pkg::mtf_range_type rng;
  logic [PW-1:0]          cyc;
  logic [PW-1:0]          on_lim;
  logic [PW-1:0]          lim;
  logic [MW-1:0]          prod;

  assign twin    = (timer_mode == mtf_pkg::MTF_MODE_TWIN_FLICKER);
  assign flicker = twin || (timer_mode == mtf_pkg::MTF_MODE_DUTY_FLICKER);
  assign rng     = (twin && !s_reg.phase_on) ? s_reg.off_rng : s_reg.on_rng;
  assign cyc     = to_units(s_reg.on_rng, set_value);
  assign prod    = MW'(cyc) * MW'(duty_pct) + mtf_pkg::PCT_HALF;
  assign on_lim  = PW'(prod / mtf_pkg::PCT_FULL);

  assign lim     = twin ? to_units(rng, s_reg.phase_on ? on_set : off_set)
                 : (flicker && s_reg.phase_on) ? on_lim : cyc;

  always_comb begin
    logic          tick;
    logic          unit;
    logic          trig;
    logic          wrap;
    logic [PW-1:0] pv_inc;
    logic [PW-1:0] remain;
    tick   = (s_reg.base_cnt == BW'(BASE_TICK_CYCLES - 1));
    wrap   = (s_reg.presc >= div_of(rng) - 1'b1);
    unit   = tick && wrap && !gate_f;
    pv_inc = s_reg.pv + PW'(1);
    remain = (lim > s_reg.pv) ? lim - s_reg.pv : '0;
    trig   = 1'b0;
    s_next = s_reg;
    s_next.rel        = 1'b0;
    s_next.start_prev = start_f;
    s_next.base_cnt   = tick ? '0 : s_reg.base_cnt + BW'(1);
    if (tick) begin
      s_next.presc = wrap ? '0 : s_reg.presc + 1'b1;
    end
    if (!s_reg.cfg_done) begin
      // Switches are only honoured when the first one is on.
      s_next.cfg_done = 1'b1;
      s_next.rel      = 1'b1;
      if (cfg_enable) begin
        s_next.on_rng     = mtf_pkg::mtf_range_type'(on_interval_range);
        s_next.off_rng    = mtf_pkg::mtf_range_type'(off_interval_range);
        s_next.down       = cfg_count_down;
        s_next.on_first   = cfg_on_start;
        s_next.short_filt = input_filter_width;
        s_next.colour_sel = display_colour_select;
      end
      // Power-up reload; non-retentive variants stay cleared.
      if (retentive) begin
        s_next.pv     = retained_pv;
        s_next.resume = 1'b1;
      end
    end else if (reset_f) begin
      s_next.running  = 1'b0;
      s_next.out      = 1'b0;
      s_next.pv       = '0;
      s_next.presc    = '0;
      s_next.phase_on = 1'b0;
      s_next.resume   = 1'b0;
      s_next.rel      = 1'b1;
    end else begin
      unique case (timer_mode)
        mtf_pkg::MTF_MODE_START_RESET: begin
          trig = start_f && (!s_reg.start_prev || s_reg.rel);
          if (!start_f) begin
            s_next.out = 1'b0;
          end
          if (trig) begin
            // A zero set never arms the timer, so the output stays off.
            s_next.running = (lim != '0);
            s_next.out     = 1'b0;
            s_next.pv      = '0;
            s_next.presc   = '0;
          end else if (s_reg.running && unit) begin
            if (pv_inc >= lim) begin
              s_next.running = 1'b0;
              s_next.pv      = '0;
              s_next.out     = 1'b1;
            end else begin
              s_next.pv = pv_inc;
            end
          end
        end
        mtf_pkg::MTF_MODE_CUMULATIVE: begin
          s_next.running = start_f;
          if (start_f && unit && s_reg.pv < lim) begin
            s_next.pv = pv_inc;
          end
          s_next.out = (lim == '0) || (s_next.pv >= lim);
        end
        default: begin
          // Both flicker modes: start is only looked at when idle.
          trig = !s_reg.running && (start_f
                 || (twin && instant_start && s_reg.rel));
          if (trig) begin
            s_next.running  = 1'b1;
            s_next.phase_on = twin ? s_reg.on_first : 1'b1;
            s_next.out      = twin ? s_reg.on_first : 1'b1;
            s_next.pv       = s_reg.resume ? s_reg.pv : '0;
            s_next.resume   = 1'b0;
            s_next.presc    = '0;
          end else if (s_reg.running && unit) begin
            if (pv_inc < lim) begin
              s_next.pv = pv_inc;
            end else if (twin || !s_reg.phase_on) begin
              s_next.phase_on = !s_reg.phase_on;
              s_next.out      = !s_reg.out;
              s_next.pv       = '0;
              s_next.presc    = '0;
            end else begin
              s_next.phase_on = 1'b0;
              s_next.out      = 1'b0;
              s_next.pv       = pv_inc;
            end
          end
        end
      endcase
    end
    s_next.pv_disp  = to_disp(rng, s_reg.down ? remain : s_reg.pv);
    s_next.sub_disp = !twin ? set_value
                      : (s_reg.phase_on ? on_set : off_set);
    s_next.colour   = colour_of(s_reg.colour_sel, s_reg.out);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg            <= '0;
      s_reg.on_rng     <= mtf_pkg::mtf_range_type'(mtf_pkg::CFG_RANGE_DEFAULT);
      s_reg.off_rng    <= mtf_pkg::mtf_range_type'(mtf_pkg::CFG_RANGE_DEFAULT);
      s_reg.down       <= mtf_pkg::CFG_BIT_DEFAULT;
      s_reg.on_first   <= mtf_pkg::CFG_BIT_DEFAULT;
      s_reg.short_filt <= mtf_pkg::CFG_BIT_DEFAULT;
      s_reg.colour_sel <= mtf_pkg::CFG_COLOUR_DEFAULT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign control_out = s_reg.out;
  assign running     = s_reg.running;
  assign pv_display  = s_reg.pv_disp;
  assign sub_display = s_reg.sub_disp;
  assign pv_store    = s_reg.pv;
  assign colour      = s_reg.colour;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_twin_trig;
    s_reg.cfg_done && !reset_f && twin && !s_reg.running
      && (start_f || (instant_start && s_reg.rel));
  endsequence

  a_reset_clears: assert property (
    s_reg.cfg_done && reset_f |=> !control_out && pv_store == '0
      && !running)
    else $error("reset did not clear timer");
  a_sr_zero_off: assert property (
    s_reg.cfg_done && timer_mode == mtf_pkg::MTF_MODE_START_RESET
      && set_value == '0 && $stable(set_value) && !control_out
      |=> !control_out)
    else $error("zero set raised output in start-reset mode");
  a_cum_zero_on: assert property (
    s_reg.cfg_done && !reset_f && timer_mode == mtf_pkg::MTF_MODE_CUMULATIVE
      && set_value == '0 |=> control_out)
    else $error("cumulative zero set did not assert output");
  a_cum_hold: assert property (
    s_reg.cfg_done && !reset_f && !start_f
      && timer_mode == mtf_pkg::MTF_MODE_CUMULATIVE |=> $stable(pv_store))
    else $error("cumulative count moved without start");
  a_flick_keeps: assert property (
    flicker && running && !reset_f ##1 flicker && !reset_f |-> running)
    else $error("flicker sequence stopped without reset");
  a_duty_start: assert property (
    s_reg.cfg_done && !reset_f && start_f && !running
      && timer_mode == mtf_pkg::MTF_MODE_DUTY_FLICKER
      |=> running && control_out)
    else $error("duty flicker did not start with output on");
  a_twin_first: assert property (
    s_twin_trig |=> running && control_out == s_reg.on_first)
    else $error("twin flicker began in wrong phase");
  a_twin_sub: assert property (
    twin && running ##1 twin |-> sub_display
      == ($past(s_reg.phase_on) ? $past(on_set) : $past(off_set)))
    else $error("sub-display shows wrong set time");
  a_cfg_frozen: assert property (
    s_reg.cfg_done |=> $stable(s_reg.on_rng) && $stable(s_reg.off_rng)
      && $stable(s_reg.short_filt) && $stable(s_reg.colour_sel))
    else $error("configuration changed after power-up");

endmodule // mtf_timer_core

//--- tb/mtf_contact_model.sv
/*
  Model of the field contacts wired to start, reset and gate.
  Assumes the bench sets the wanted levels just after a rising edge.
*/
`timescale 1ns/1ps
module mtf_contact_model (
  input  wire logic clk,
  input  wire logic want_start,
  input  wire logic want_reset,
  input  wire logic want_gate,
  output logic      start_in,
  output logic      reset_in,
  output logic      gate_in,
  output logic      cfg_enable
);
  // The first switch is tied on, so the power-up switches are always honoured.
  assign cfg_enable = 1'b1;
  // Contacts change one cycle after the request, as a relay lags.
  always @(posedge clk) begin
    start_in <= want_start;
    reset_in <= want_reset;
    gate_in  <= want_gate;
  end
endmodule // mtf_contact_model

//--- tb/multimode_twin_flicker_timer_bench.sv
/*
  Self-checking bench of the timer core with scaled counts.
  Assumes the contact model drives the field inputs.
*/
`timescale 1ns/1ps
module multimode_twin_flicker_timer_bench;
  localparam int BT = 10;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ws = 1'b0;
  logic wr = 1'b0;
  logic wg = 1'b0;
  logic ret = 1'b0;
  logic inst = 1'b0;
  logic start_in, reset_in, gate_in, cfg_enable;
  logic [1:0] off_rng = 2'h0;
  logic [1:0] on_rng = 2'h0;
  logic cnt_dn = 1'b0;
  logic on_st = 1'b0;
  logic flt = 1'b0;
  logic [3:0] col_sel = 4'h0;
  mtf_pkg::mtf_mode_type mode = mtf_pkg::MTF_MODE_START_RESET;
  logic [13:0] set_v = 14'h0000;
  logic [13:0] on_s = 14'h000C;
  logic [13:0] off_s = 14'h000F;
  logic [6:0] duty = 7'h22;
  logic ctl, run;
  logic [13:0] pv_d, sub_d, pv_s, p;
  mtf_pkg::mtf_colour_type colour;
  int fail_count = 0;
  int checked = 0;
  int n;

  always #5 clk = ~clk;

  mtf_contact_model partner (.clk(clk), .want_start(ws), .want_reset(wr),
    .want_gate(wg), .start_in(start_in), .reset_in(reset_in),
    .gate_in(gate_in), .cfg_enable(cfg_enable));

  mtf_timer_core #(.BASE_TICK_CYCLES(BT), .FILTER_LONG_CYCLES(8),
    .FILTER_SHORT_CYCLES(2)) dut (.clk(clk), .sys_rst(sys_rst),
    .start_in(start_in), .reset_in(reset_in), .gate_in(gate_in),
    .cfg_enable(cfg_enable), .off_interval_range(off_rng),
    .on_interval_range(on_rng), .cfg_count_down(cnt_dn),
    .cfg_on_start(on_st), .input_filter_width(flt),
    .display_colour_select(col_sel), .timer_mode(mode),
    .retentive(ret), .instant_start(inst), .set_value(set_v),
    .on_set(on_s), .off_set(off_s), .duty_pct(duty),
    .retained_pv(14'h0005), .control_out(ctl), .running(run),
    .pv_display(pv_d), .sub_display(sub_d), .pv_store(pv_s),
    .colour(colour));

  task automatic fail(input string m);
    fail_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp) fail(m);
  endtask
  task automatic chv(input logic [13:0] got, input logic [13:0] exp,
                     input string m);
    checked++;
    if (got !== exp) fail(m);
  endtask
  task automatic chn(input integer v, input int lo, input int hi,
                     input string m);
    checked++;
    if ($isunknown(v) || v < lo || v > hi) fail(m);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic st(input logic s, input logic r, input logic g);
    @(posedge clk);
    ws <= s;
    wr <= r;
    wg <= g;
  endtask
  // Waits on the run flag or the output, and counts the cycles taken.
  task automatic wt(input logic sel, input logic v, output int k);
    k = 0;
    while ((sel ? run : ctl) !== v && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000) fail("wait timed out");
  endtask
  task automatic pwr(input mtf_pkg::mtf_mode_type m, input logic [1:0] rg,
                     input logic dn, input logic os, input logic fw);
    @(posedge clk);
    sys_rst <= 1'b1;
    mode <= m;
    on_rng <= rg;
    off_rng <= rg;
    cnt_dn <= dn;
    on_st <= os;
    flt <= fw;
    ws <= 1'b0;
    wr <= 1'b0;
    wg <= 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(2);
  endtask
  task automatic finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic t_zero;
    col_sel <= mtf_pkg::SEL_RED_GREEN;
    set_v <= 14'h0000;
    pwr(mtf_pkg::MTF_MODE_START_RESET, 2'h0, 1'b0, 1'b0, 1'b0);
    st(1'b1, 1'b0, 1'b0);
    cyc(60);
    chk(ctl, 1'b0, "zero set drove output");
    chk(colour === mtf_pkg::MTF_COLOUR_RED, 1'b1, "colour off");
    @(posedge clk);
    mode <= mtf_pkg::MTF_MODE_CUMULATIVE;
    cyc(4);
    chk(ctl, 1'b1, "zero set output late");
    chk(colour === mtf_pkg::MTF_COLOUR_GREEN, 1'b1, "colour on");
    $display("test zero done");
  endtask

  task automatic t_cum;
    int u;
    set_v <= 14'h270F;
    for (int r = 0; r < 4; r++) begin
      pwr(mtf_pkg::MTF_MODE_CUMULATIVE, r[1:0], 1'b0, 1'b0, 1'b0);
      on_rng <= 2'h3 - r[1:0];
      st(1'b1, 1'b0, 1'b0);
      cyc(200);
      st(1'b0, 1'b0, 1'b0);
      cyc(20);
      p = pv_s;
      cyc(100);
      chv(pv_s, p, "count moved with start off");
      u = (r == 0) ? BT : (r == 1) ? BT * 10 : (r == 2) ? BT * 100 : BT * 100;
      chn(p, 200 / u - 1, 200 / u + 1, "range unit");
    end
    $display("test cumulative done");
  endtask

  task automatic t_down;
    set_v <= 14'h0032;
    pwr(mtf_pkg::MTF_MODE_CUMULATIVE, 2'h0, 1'b1, 1'b0, 1'b0);
    st(1'b1, 1'b0, 1'b0);
    cyc(100);
    st(1'b1, 1'b0, 1'b1);
    cyc(20);
    chv(pv_d, 14'h0032 - pv_s, "remaining time shown");
    st(1'b0, 1'b1, 1'b0);
    cyc(20);
    chv(pv_s, 14'h0000, "field reset kept value");
    $display("test down done");
  endtask

  task automatic t_duty;
    set_v <= 14'h0028;
    pwr(mtf_pkg::MTF_MODE_DUTY_FLICKER, 2'h0, 1'b0, 1'b0, 1'b0);
    st(1'b1, 1'b0, 1'b0);
    wt(1'b1, 1'b1, n);
    chk(ctl, 1'b1, "flicker did not start on");
    st(1'b0, 1'b0, 1'b0);
    wt(1'b0, 1'b0, n);
    // Forty units at 34 percent is 13.6, so rounding gives 14 units.
    chn(n, 131, 140, "on portion");
    // A new start edge in the off phase must not restart the cycle.
    st(1'b1, 1'b0, 1'b0);
    wt(1'b0, 1'b1, n);
    chn(n, 254, 266, "off portion");
    st(1'b1, 1'b1, 1'b0);
    cyc(20);
    chk(ctl, 1'b0, "output under reset");
    chk(run, 1'b0, "timing under reset");
    st(1'b1, 1'b0, 1'b0);
    wt(1'b1, 1'b1, n);
    chn(n, 0, 20, "held start at reset release");
    $display("test duty done");
  endtask

  task automatic t_twin;
    for (int o = 0; o < 2; o++) begin
      pwr(mtf_pkg::MTF_MODE_TWIN_FLICKER, 2'h0, 1'b0, o[0], 1'b0);
      @(posedge clk);
      on_st <= !o[0];
      st(1'b1, 1'b0, 1'b0);
      wt(1'b1, 1'b1, n);
      chk(ctl, o[0], "first twin phase");
      cyc(2);
      chv(sub_d, o[0] ? on_s : off_s, "sub display first");
      wt(1'b0, !o[0], n);
      chn(n, (o ? 120 : 150) - 12, (o ? 120 : 150) + 2, "phase");
      cyc(2);
      chv(sub_d, o[0] ? off_s : on_s, "sub display second");
    end
    $display("test twin done");
  endtask

  task automatic t_filter;
    for (int f = 0; f < 2; f++) begin
      pwr(mtf_pkg::MTF_MODE_DUTY_FLICKER, 2'h0, 1'b0, 1'b0, f[0]);
      st(1'b1, 1'b0, 1'b0);
      cyc(5);
      st(1'b0, 1'b0, 1'b0);
      cyc(30);
      chk(run, f[0], "pulse filter");
    end
    $display("test filter done");
  endtask

  task automatic t_sr;
    set_v <= 14'h000A;
    pwr(mtf_pkg::MTF_MODE_START_RESET, 2'h0, 1'b0, 1'b0, 1'b0);
    st(1'b1, 1'b0, 1'b0);
    wt(1'b1, 1'b1, n);
    wt(1'b1, 1'b0, n);
    chn(n, 88, 102, "set time");
    chk(ctl, 1'b1, "expiry output");
    chv(pv_s, 14'h0000, "expiry clears");
    st(1'b0, 1'b0, 1'b0);
    cyc(20);
    chk(ctl, 1'b0, "output after start off");
    st(1'b1, 1'b0, 1'b0);
    wt(1'b1, 1'b1, n);
    chn(n, 0, 20, "retrigger");
    $display("test start reset done");
  endtask

  task automatic t_var;
    ret <= 1'b1;
    set_v <= 14'h0028;
    pwr(mtf_pkg::MTF_MODE_DUTY_FLICKER, 2'h0, 1'b0, 1'b0, 1'b0);
    chv(pv_s, 14'h0005, "retained value lost at power up");
    st(1'b1, 1'b0, 1'b0);
    wt(1'b1, 1'b1, n);
    chv(pv_s, 14'h0005, "resume did not keep value");
    ret <= 1'b0;
    inst <= 1'b1;
    pwr(mtf_pkg::MTF_MODE_TWIN_FLICKER, 2'h0, 1'b0, 1'b0, 1'b0);
    chv(pv_s, 14'h0000, "value kept without retention");
    wt(1'b1, 1'b1, n);
    chn(n, 0, 3, "no automatic start");
    inst <= 1'b0;
    $display("test variants done");
  endtask

  initial begin
    #200000;
    fail("watchdog expired");
    finish_test;
  end

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(2);
    chk(ctl, 1'b0, "output after power up");
    chv(pv_s, 14'h0000, "value after power up");
    chk(colour === mtf_pkg::MTF_COLOUR_RED, 1'b1, "default colour");
    t_zero;
    t_cum;
    t_down;
    t_duty;
    t_twin;
    t_filter;
    t_sr;
    t_var;
    finish_test;
  end
endmodule // multimode_twin_flicker_timer_bench
